// file: core/dsa_cfg.svh
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH
// Data path widths
`define DSA_DW 16
`define DSA_AW 16
`define DSA_BW 8
`define DSA_NEAR_W 13
// Pointer steps for post-increment
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002
// Bit positions
`define DSA_LSB 0
`define DSA_SIGN 7
// Near region upper bound
`define DSA_NEAR_TOP 16'h1FFF
`define DSA_ZERO_BYTE 8'h00
`define DSA_ONES_BYTE 8'hFF
`define DSA_ZERO_WORD 16'h0000
`define DSA_NO_LANES 2'h0
// Write lane codes: bit one high byte, bit zero low byte
`define DSA_LANE_LO 2'h1
`define DSA_LANE_HI 2'h2
`define DSA_LANE_BOTH 2'h3
// Byte half boundaries inside a word
`define DSA_LO_MSB 7
`define DSA_HI_LSB 8
`define DSA_HI_MSB 15
// Word address starts above the byte select bit
`define DSA_WADDR_LSB 1
`endif

// file: core/dsa_pkg.sv
package dsa_pkg;
	// Addressing mode of the access
	typedef enum logic [1:0] {
		DSA_DIRECT_NEAR = 2'h0,
		DSA_DIRECT_FULL = 2'h1,
		DSA_INDIRECT = 2'h3,
		DSA_INDIRECT_INC = 2'h2
	} dsa_mode_e;
	// Operation applied to the working register result
	typedef enum logic [1:0] {
		DSA_OP_MOVE = 2'h0,
		DSA_OP_SIGN_EXT = 2'h1,
		DSA_OP_ZERO_EXT = 2'h3
	} dsa_op_e;
	// Request from the core pipeline
	typedef struct packed {
		logic valid;
		logic write;
		logic byteOp;
		logic wordOnly;
		dsa_mode_e mode;
		dsa_op_e op;
		logic [15:0] directAddr;
		logic [15:0] sourceWorkingPointer;
		logic [15:0] writeData;
		logic [15:0] destWorking;
	} dsa_req_s;
	// Result toward the core
	typedef struct packed {
		logic done;
		logic addrErrorTrap;
		logic [15:0] readData;
		logic [15:0] destWorkingNew;
		logic [15:0] pointerNew;
		logic pointerWrite;
		logic [15:0] effectiveAddress;
	} dsa_rsp_s;
	// Memory side strobes
	typedef struct packed {
		logic rdEn;
		logic [1:0] wrLane;
		logic [14:0] wordAddr;
		logic [15:0] wrData;
	} dsa_mem_s;
	// All block state
	typedef struct packed {
		dsa_rsp_s rsp;
		dsa_mem_s mem;
	} dsa_state_s;
endpackage : dsa_pkg

// file: core/dsa_access.sv
`timescale 1ns/1ps
`include "dsa_cfg.svh"
module dsa_access (
	input wire logic clk,
	input wire logic rst_n,
	input wire dsa_pkg::dsa_req_s req,
	input wire logic [15:0] memRdData,
	output dsa_pkg::dsa_rsp_s rsp,
	output dsa_pkg::dsa_mem_s mem
);
	import dsa_pkg::*;

	dsa_state_s state_r;
	dsa_state_s state_nxt;
	logic [15:0] effAddr;
	logic isByte;
	logic misaligned;
	logic [7:0] laneByte;
	logic [15:0] loadVal;
	logic [15:0] step;

	////////////////////////////////////////////////////////////////////////
	// Address generation and alignment check
	always_comb
	begin
		isByte = req.byteOp && !req.wordOnly;
		unique case (req.mode)
			DSA_DIRECT_NEAR: effAddr = {{(`DSA_AW - `DSA_NEAR_W){1'b0}},
				req.directAddr[`DSA_NEAR_W - 1:0]};
			DSA_DIRECT_FULL: effAddr = req.directAddr;
			default: effAddr = req.sourceWorkingPointer;
		endcase
		misaligned = !isByte && effAddr[`DSA_LSB];
		step = isByte ? `DSA_STEP_BYTE : `DSA_STEP_WORD;
	end

	////////////////////////////////////////////////////////////////////////
	// Read lane steering and register result
	always_comb
	begin
		// Whole word fetched, address bit zero picks the half
		laneByte = effAddr[`DSA_LSB] ? memRdData[`DSA_HI_MSB:`DSA_HI_LSB]
			: memRdData[`DSA_LO_MSB:`DSA_LSB];
		// Byte loads keep the register's upper half
		if (isByte)
			loadVal = {req.destWorking[`DSA_HI_MSB:`DSA_HI_LSB], laneByte};
		else
			loadVal = memRdData;
		// Extension works on the low byte of the loaded value
		unique case (req.op)
			DSA_OP_SIGN_EXT: loadVal = {{`DSA_BW{loadVal[`DSA_SIGN]}},
				loadVal[`DSA_LO_MSB:`DSA_LSB]};
			DSA_OP_ZERO_EXT: loadVal = {`DSA_ZERO_BYTE, loadVal[`DSA_LO_MSB:`DSA_LSB]};
			default: loadVal = loadVal;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: strobes and results registered for one cycle
	always_comb
	begin
		state_nxt = '0;
		state_nxt.mem.wordAddr = effAddr[`DSA_AW - 1:`DSA_WADDR_LSB];
		state_nxt.rsp.effectiveAddress = effAddr;
		if (req.valid)
		begin
			state_nxt.rsp.done = 1'b1;
			state_nxt.rsp.addrErrorTrap = misaligned;
			state_nxt.mem.rdEn = !req.write;
			if (req.write && !misaligned)
			begin
				if (isByte)
				begin
					// One lane only; byte copied to both halves
					state_nxt.mem.wrLane = effAddr[`DSA_LSB] ? `DSA_LANE_HI : `DSA_LANE_LO;
					state_nxt.mem.wrData = {req.writeData[`DSA_LO_MSB:`DSA_LSB],
						req.writeData[`DSA_LO_MSB:`DSA_LSB]};
				end
				else
				begin
					// Aligned word writes both lanes
					state_nxt.mem.wrLane = `DSA_LANE_BOTH;
					state_nxt.mem.wrData = req.writeData;
				end
			end
			state_nxt.rsp.readData = req.write ? `DSA_ZERO_WORD : loadVal;
			state_nxt.rsp.destWorkingNew = req.write ? req.destWorking : loadVal;
			if (req.mode == DSA_INDIRECT_INC)
			begin
				state_nxt.rsp.pointerWrite = 1'b1;
				state_nxt.rsp.pointerNew = req.sourceWorkingPointer + step;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign rsp = state_r.rsp;
	assign mem = state_r.mem;

	////////////////////////////////////////////////////////////////////////
	// Checks

	// No write strobe may leave with a trap
	misalign_nowrite_a: assert property (@(posedge clk) disable iff (!rst_n)
		rsp.addrErrorTrap |-> mem.wrLane == `DSA_NO_LANES)
		else $error("write strobe during misaligned access");

	// Odd full direct word access traps
	trap_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !(req.byteOp && !req.wordOnly) && req.directAddr[`DSA_LSB]
		&& req.mode == DSA_DIRECT_FULL |=> rsp.addrErrorTrap)
		else $error("odd word access not trapped");

	// Trapped access still completes
	trap_done_a: assert property (@(posedge clk) disable iff (!rst_n)
		rsp.addrErrorTrap |-> rsp.done)
		else $error("trap without completion");

	// Any odd word access traps, whatever the mode
	misalign_trap_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !isByte && effAddr[`DSA_LSB] |=> rsp.addrErrorTrap)
		else $error("misaligned word access missed");

	// Byte accesses never trap
	byte_no_trap_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && isByte |=> !rsp.addrErrorTrap)
		else $error("byte access trapped");

	// Trap is a single pulse per request
	trap_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		!req.valid |=> !rsp.addrErrorTrap)
		else $error("trap without request");

	// Every request completes one cycle later
	done_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid |=> rsp.done)
		else $error("request not completed");

	// Misaligned read still hands the fetched word back
	misread_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && misaligned && req.op == DSA_OP_MOVE
		|=> rsp.readData == $past(memRdData))
		else $error("misaligned read lost its data");

	////////////////////////////////////////////////////////////////////////
	// Checks: write lanes and memory strobes

	// Byte write touches one lane only
	byte_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.write && req.byteOp && !req.wordOnly |=>
		mem.wrLane == `DSA_LANE_LO || mem.wrLane == `DSA_LANE_HI)
		else $error("byte write touched both lanes");

	// High lane only for odd byte address
	hi_lane_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.wrLane == `DSA_LANE_HI |-> rsp.effectiveAddress[`DSA_LSB])
		else $error("high lane at even address");

	// Low lane only for even byte address
	lo_lane_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.wrLane == `DSA_LANE_LO |-> !rsp.effectiveAddress[`DSA_LSB])
		else $error("low lane at odd address");

	// Both lanes only at an even address
	both_lane_even_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.wrLane == `DSA_LANE_BOTH |-> !rsp.effectiveAddress[`DSA_LSB])
		else $error("word write at odd address");

	// Shared word decode follows the effective address
	word_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.wordAddr == rsp.effectiveAddress[`DSA_AW - 1:`DSA_WADDR_LSB])
		else $error("word address mismatch");

	// A read strobes the read enable and no lane
	read_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write |=> mem.rdEn && mem.wrLane == `DSA_NO_LANES)
		else $error("read strobes wrong");

	// Read and write strobes never together
	rd_wr_excl_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.rdEn |-> mem.wrLane == `DSA_NO_LANES)
		else $error("read and write strobed together");

	// No completion, read strobe or write lane leaves without a request
	idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		!req.valid |=> !rsp.done && !mem.rdEn && mem.wrLane == `DSA_NO_LANES)
		else $error("strobe without request");

	// Byte write data sits on both halves
	byte_replica_a: assert property (@(posedge clk) disable iff (!rst_n)
		mem.wrLane == `DSA_LANE_LO || mem.wrLane == `DSA_LANE_HI |->
		mem.wrData[`DSA_HI_MSB:`DSA_HI_LSB] == mem.wrData[`DSA_LO_MSB:`DSA_LSB])
		else $error("byte write data not replicated");

	// Aligned word write carries the whole word
	word_write_data_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.write && !isByte && !misaligned
		|=> mem.wrData == $past(req.writeData))
		else $error("word write data wrong");

	// Word-only writes at an even address use both lanes even when marked byte
	word_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.wordOnly && req.write && !effAddr[`DSA_LSB]
		|=> mem.wrLane == `DSA_LANE_BOTH)
		else $error("word-only request took byte form");

	////////////////////////////////////////////////////////////////////////
	// Checks: addresses and pointer update

	// Post-increment step follows the operand size
	step_size_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.mode == DSA_INDIRECT_INC |=>
		rsp.pointerNew - $past(req.sourceWorkingPointer)
		== ($past(req.byteOp && !req.wordOnly) ? `DSA_STEP_BYTE : `DSA_STEP_WORD))
		else $error("wrong post-increment step");

	// Pointer written back only by post-increment
	pointer_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.mode != DSA_INDIRECT_INC |=> !rsp.pointerWrite)
		else $error("pointer written without increment");

	// Indirect modes use the pointer as address
	indirect_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && (req.mode == DSA_INDIRECT || req.mode == DSA_INDIRECT_INC)
		|=> rsp.effectiveAddress == $past(req.sourceWorkingPointer))
		else $error("indirect address wrong");

	// Near direct stays inside the near region
	near_range_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.mode == DSA_DIRECT_NEAR |=>
		rsp.effectiveAddress <= `DSA_NEAR_TOP)
		else $error("near address out of range");

	// Near direct keeps the thirteen field bits
	near_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.mode == DSA_DIRECT_NEAR |=>
		rsp.effectiveAddress[`DSA_NEAR_W - 1:`DSA_LSB]
		== $past(req.directAddr[`DSA_NEAR_W - 1:`DSA_LSB]))
		else $error("near address bits lost");

	// Full direct reaches the whole data space
	full_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.mode == DSA_DIRECT_FULL
		|=> rsp.effectiveAddress == $past(req.directAddr))
		else $error("full direct address wrong");

	////////////////////////////////////////////////////////////////////////
	// Checks: read data and register result

	// Chosen byte lands on the low data bits
	byte_read_lane_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && isByte && req.op == DSA_OP_MOVE |=>
		rsp.readData[`DSA_LO_MSB:`DSA_LSB] == ($past(effAddr[`DSA_LSB])
		? $past(memRdData[`DSA_HI_MSB:`DSA_HI_LSB]) : $past(memRdData[`DSA_LO_MSB:`DSA_LSB])))
		else $error("byte read on wrong lane");

	// Aligned word read passes the whole word
	word_read_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && !isByte && req.op == DSA_OP_MOVE
		|=> rsp.readData == $past(memRdData))
		else $error("word read data wrong");

	// Writes leave the register untouched
	write_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && req.write |=> rsp.destWorkingNew == $past(req.destWorking)
		&& rsp.readData == `DSA_ZERO_WORD)
		else $error("write altered register result");

	// Zero extend clears the upper byte
	zero_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.op == DSA_OP_ZERO_EXT |=>
		rsp.destWorkingNew[`DSA_HI_MSB:`DSA_HI_LSB] == `DSA_ZERO_BYTE)
		else $error("zero extend left upper byte");

	// Zero extend of a word keeps its low byte
	zero_low_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.op == DSA_OP_ZERO_EXT && !isByte |=>
		rsp.destWorkingNew[`DSA_LO_MSB:`DSA_LSB] == $past(memRdData[`DSA_LO_MSB:`DSA_LSB]))
		else $error("zero extend changed low byte");

	// Sign extend copies bit seven upward
	sign_ext_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.op == DSA_OP_SIGN_EXT |=>
		rsp.destWorkingNew[`DSA_HI_MSB:`DSA_HI_LSB] == (rsp.destWorkingNew[`DSA_SIGN]
		? `DSA_ONES_BYTE : `DSA_ZERO_BYTE))
		else $error("sign extend wrong");

	// Sign extend of a word keeps its low byte
	sign_low_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.op == DSA_OP_SIGN_EXT && !isByte |=>
		rsp.destWorkingNew[`DSA_LO_MSB:`DSA_LSB] == $past(memRdData[`DSA_LO_MSB:`DSA_LSB]))
		else $error("sign extend changed low byte");

	// Byte load keeps the register's upper half
	byte_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
		req.valid && !req.write && req.byteOp && !req.wordOnly
		&& req.op == DSA_OP_MOVE |=>
		rsp.destWorkingNew[`DSA_HI_MSB:`DSA_HI_LSB]
		== $past(req.destWorking[`DSA_HI_MSB:`DSA_HI_LSB]))
		else $error("byte load altered high byte");
endmodule : dsa_access

// file: tb/dsa_mem_model.sv
`timescale 1ns/1ps
// Data words on the far side
module dsa_mem_model (
	input wire logic clk,
	input wire dsa_pkg::dsa_mem_s mem,
	input wire logic [15:0] addr,
	output logic [15:0] rdData
);
	import dsa_pkg::*;
	logic [15:0] store [0:15];
	// Whole word comes back for any access
	assign rdData = store[addr[4:1]];
	// Shared word decode, one strobe per lane
	always @(posedge clk)
	begin
		if (mem.wrLane[0]) store[mem.wordAddr[3:0]][7:0] <= mem.wrData[7:0];
		if (mem.wrLane[1]) store[mem.wordAddr[3:0]][15:8] <= mem.wrData[15:8];
	end
	// Mixed contents
	initial
		for (int k = 0; k < 16; k++) store[k] = 16'h9C3A ^ 16'(k * 16'h1111);
endmodule : dsa_mem_model

// file: tb/tb_data_space_byte_word_access.sv
`timescale 1ns/1ps
module tb_data_space_byte_word_access;
	import dsa_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	dsa_req_s req = '0;
	dsa_rsp_s rsp;
	dsa_mem_s mem;
	logic [15:0] rdWord;
	logic [15:0] lfsrR = 16'h002A;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	// Address the access should use
	function automatic logic [15:0] eaOf(input dsa_req_s r);
		return r.mode == DSA_DIRECT_NEAR ? {3'h0, r.directAddr[12:0]} :
			r.mode == DSA_DIRECT_FULL ? r.directAddr : r.sourceWorkingPointer;
	endfunction : eaOf
	// Register result a read should give
	function automatic logic [15:0] expLoad(input dsa_req_s r, input logic [15:0] m);
		logic [15:0] e;
		logic [15:0] v;
		e = eaOf(r);
		v = (r.byteOp & ~r.wordOnly) ? {r.destWorking[15:8], (e[0] ? m[15:8] : m[7:0])} : m;
		return r.op == DSA_OP_SIGN_EXT ? {{8{v[7]}}, v[7:0]} :
			r.op == DSA_OP_ZERO_EXT ? {8'h00, v[7:0]} : v;
	endfunction : expLoad
	function automatic logic [15:0] nextRand();
		lfsrR = {lfsrR[14:0], lfsrR[15] ^ lfsrR[13] ^ lfsrR[12] ^ lfsrR[10]};
		return lfsrR;
	endfunction : nextRand
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	dsa_access dut (.clk(clk), .rst_n(rst_n), .req(req), .memRdData(rdWord), .rsp(rsp),
		.mem(mem));
	dsa_mem_model mdl (.clk(clk), .mem(mem), .addr(eaOf(req)), .rdData(rdWord));
	// Clock and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_mismatch++;
			end_sim();
		end
	end
	// Reset, corner cases, then random traffic
	initial
	begin
		dsa_req_s r;
		logic [15:0] x, y, m, e, dwn;
		logic b, mis;
		logic [7:0] bt;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk(rsp.done === 1'b0 && mem.wrLane === 2'h0, "reset");
		$display("reset test done");
		for (int i = 0; i < 400; i++)
		begin
			x = nextRand();
			y = nextRand();
			r = '{1'b1, x[0], x[1], x[2] & x[3], dsa_mode_e'(x[5:4]),
				dsa_op_e'(x[7:6] == 2'h2 ? 2'h0 : x[7:6]), y, {y[7:0], x[15:8]}, x ^ y, y};
			if (i < 2) r = '{1'b1, i[0], 1'b0, 1'b0, DSA_INDIRECT_INC, DSA_OP_MOVE,
				16'h0000, 16'hFFFF, 16'hA5A5, 16'h1234};
			if (i >= 2 && i < 4) r = '{1'b1, i[0], 1'b1, 1'b0, DSA_INDIRECT_INC,
				DSA_OP_SIGN_EXT, 16'h0000, 16'h0003, 16'h5A80, 16'hBEEF};
			@(posedge clk);
			req <= r;
			@(negedge clk);
			m = rdWord;
			@(negedge clk);
			e = eaOf(r);
			b = r.byteOp & ~r.wordOnly;
			mis = ~b & e[0];
			bt = e[0] ? m[15:8] : m[7:0];
			dwn = expLoad(r, m);
			chk(rsp.done === 1'b1 && rsp.addrErrorTrap === mis, "trap");
			chk(rsp.effectiveAddress === e, "address");
			chk(mem.wrLane === (r.write & ~mis ? (b ? (e[0] ? 2'h2 : 2'h1) : 2'h3) : 2'h0),
				"lanes");
			chk(~r.write | mis | mem.wrData === (b ? {2{r.writeData[7:0]}} : r.writeData),
				"write data");
			chk(mem.wordAddr === e[15:1] && mem.rdEn === ~r.write, "word address");
			chk(r.write | ~b | rsp.readData[7:0] === bt, "byte read");
			chk(r.write ? rsp.destWorkingNew === r.destWorking : rsp.destWorkingNew === dwn
				&& rsp.readData === dwn, "register");
			chk(rsp.pointerWrite === (r.mode == DSA_INDIRECT_INC) && (r.mode != DSA_INDIRECT_INC
				|| rsp.pointerNew === e + (b ? 16'h0001 : 16'h0002)), "pointer");
		end
		$display("random test done");
		end_sim();
	end
endmodule : tb_data_space_byte_word_access
